// >>> hw/spi_chain_consts.svh
// constants of the daisy-chained serial control port
// assumes it is included by bare name from the package and the design file
`ifndef SPI_CHAIN_CONSTS_SVH
`define SPI_CHAIN_CONSTS_SVH

// control byte field positions
`define CTL_BCAST_BIT 7
`define CTL_READ_BIT 6
`define CTL_ONE_BIT 5
`define CTL_ZERO_BIT 4
// channel id occupies control bits 3..0, id bit 0 at control bit 3
`define CTL_ID_MSB 3
`define CTL_MARK_VAL 2'h2

// widths and sizes
`define BYTE_W 8
`define ADDR_W 6
`define REG_COUNT 64
`define BIT_CNT_W 3
`define LAST_BIT 3'h7
`define ID_FIRST_BIT 3'h4

// reset values
`define REG_RST_VAL 8'h00
`define BIT_CNT_RST 3'h0

`endif

// >>> hw/spi_chain_pkg.sv
// types shared by the daisy-chained serial control port
// assumes spi_chain_consts.svh sits beside it
`include "spi_chain_consts.svh"

package spi_chain_pkg;

  // serial sequencer: control byte, address byte, one or two data bytes
  typedef enum logic [1:0] {
    ST_CTRL,
    ST_ADDR,
    ST_DATA0,
    ST_DATA1
  } seq_state_t;

  // register write reported to the core side
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [2*`BYTE_W-1:0] data;
    logic two_bytes;
  } wr_evt_t;

endpackage

// >>> hw/spi_chain_port.sv
// serial control port with daisy-chain pass-through and 64-byte register file
// assumes: serial clock is a clock of its own, chip select and data-in are
// launched by the controller on that clock, core clock is 50 MHz
//
// Overview of operation
// - serial pins plus chain pass-through, sixteen deep
// - control byte, address byte, one/two data bytes
// - only low six address bits are decoded
// - every byte shifted most significant bit first
// - eight clocks per byte, clock idles high
// - chip select off-boundary resets to control byte
// - bit 7 broadcast, only used for writes
// - bit 6 one reads, zero writes
// - four-bit channel id, sent lsb first
// - chain position gives channel number
// - id decremented before passing downstream
// - only id zero device acts
// - broadcast passes id unchanged, all write
// - serial clock level at reset selects mode
`timescale 1ns/10ps
`default_nettype none
`include "spi_chain_consts.svh"

module spi_chain_port (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wide_data,
  output logic o_serial_mode,
  output logic o_wr_strobe,
  output spi_chain_pkg::wr_evt_t o_wr_evt,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  output logic o_chain_pass_out
);
  import spi_chain_pkg::*;

  // ---- core domain ----

  // serial clock pin seen as plain data for the mode strap
  logic strap_s1_r;
  logic strap_s2_r;
  // reset seen one cycle late, to find its release
  logic rst_d_r;
  // latched interface mode, one means serial control
  logic mode_r;
  // write toggle from the link side, three stages
  logic wtog_s1_r;
  logic wtog_s2_r;
  logic wtog_s3_r;
  logic wr_strobe_r;
  wr_evt_t wr_evt_r;
  // write handover from the link side, flipped and held there
  logic wtog_r;
  wr_evt_t wr_hold_r;

  // write event arrives as a toggle change
  wire core_wr_seen = wtog_s2_r ^ wtog_s3_r;
  // release edge of the synchronous reset
  wire rst_release = rst_d_r & ~i_srst;

  // two-flop synchroniser for the strap level
  always_ff @(posedge i_core_clk) begin
    strap_s1_r <= i_spi_sclk;
    strap_s2_r <= strap_s1_r;
  end

  // mode latched at release
  // the strap is caught by a clocked step at release, never by the reset itself
  always_ff @(posedge i_core_clk) begin
    rst_d_r <= i_srst;
    if (rst_release) begin
      mode_r <= strap_s2_r;
    end
  end

  // write toggle synchroniser and event capture
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wtog_s1_r <= 1'b0;
      wtog_s2_r <= 1'b0;
      wtog_s3_r <= 1'b0;
      wr_strobe_r <= 1'b0;
      wr_evt_r <= '0;
    end else begin
      wtog_s1_r <= wtog_r;
      wtog_s2_r <= wtog_s1_r;
      wtog_s3_r <= wtog_s2_r;
      wr_strobe_r <= core_wr_seen;
      // the held word is stable: the next write is at least 16 serial clocks away
      if (core_wr_seen) begin
        wr_evt_r <= wr_hold_r;
      end
    end
  end

  assign o_serial_mode = mode_r;
  assign o_wr_strobe = wr_strobe_r;
  assign o_wr_evt = wr_evt_r;

  // ---- link domain ----

  // reset, mode and width crossed into the serial clock domain
  logic lrst_s1_r;
  logic lrst_s2_r;
  logic lmode_s1_r;
  logic lmode_s2_r;
  logic lwide_s1_r;
  logic lwide_s2_r;
  // sequencer state and bit position within the byte
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [`BIT_CNT_W-1:0] bit_cnt_r;
  logic [`BYTE_W-2:0] shift_r;
  // fields of the current operation
  logic bcast_r;
  logic read_r;
  logic sel_r;
  logic [`ADDR_W-1:0] addr_r;
  logic [`BYTE_W-1:0] data0_r;
  // outgoing read word, first byte in the upper half
  logic [2*`BYTE_W-1:0] tx_r;
  // serial decrement of the passing id
  logic borrow_r;
  logic bcast_first_r;
  // data output stage, moved on falling edges
  logic sdo_r;
  logic sdo_oe_r;
  // register file written through the port
  logic [`BYTE_W-1:0] regs_r [`REG_COUNT];

  // assembled byte on its last bit
  wire [`BYTE_W-1:0] rx_byte = {shift_r, i_spi_sdi};
  wire byte_done = (bit_cnt_r == `LAST_BIT) & ~i_spi_cs_n & lmode_s2_r;
  wire [`ADDR_W-1:0] rx_addr = rx_byte[`ADDR_W-1:0];
  wire [`ADDR_W-1:0] rx_addr_p1 = rx_addr + `ADDR_W'(1);
  wire [`ADDR_W-1:0] addr_p1 = addr_r + `ADDR_W'(1);
  // id bits arrive in control bits 3..0
  wire [3:0] rx_id = rx_byte[`CTL_ID_MSB:0];
  // act only on id zero, or on broadcast
  wire rx_sel = (rx_byte[`CTL_BCAST_BIT] | (rx_id == 4'h0))
    & (rx_byte[`CTL_ONE_BIT:`CTL_ZERO_BIT] == `CTL_MARK_VAL);
  // a write takes effect only when selected and not a read
  wire do_write = sel_r & ~read_r;
  // last data byte of the operation
  wire last_data = (state_r == ST_DATA1) | ((state_r == ST_DATA0) & ~lwide_s2_r);
  // id bits of the control byte are passing
  wire in_id = (state_r == ST_CTRL) & (bit_cnt_r >= `ID_FIRST_BIT);
  // drive only for a selected, non-broadcast read data byte
  wire drive_now = sel_r & read_r & ~bcast_r & lmode_s2_r
    & ((state_r == ST_DATA0) | (state_r == ST_DATA1));
  // msb first: first byte from bit 15, second from bit 7
  wire [3:0] tx_idx = (state_r == ST_DATA1) ? {1'b0, ~bit_cnt_r} : {1'b1, ~bit_cnt_r};

  // reset and configuration synchronisers on the serial clock
  // the link reset needs serial clock edges to take hold
  always_ff @(posedge i_spi_sclk) begin
    lrst_s1_r <= i_srst;
    lrst_s2_r <= lrst_s1_r;
    lmode_s1_r <= mode_r;
    lmode_s2_r <= lmode_s1_r;
    lwide_s1_r <= i_wide_data;
    lwide_s2_r <= lwide_s1_r;
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_CTRL: begin
        state_nxt = ST_ADDR;
      end
      ST_ADDR: begin
        state_nxt = ST_DATA0;
      end
      ST_DATA0: begin
        state_nxt = lwide_s2_r ? ST_DATA1 : ST_CTRL;
      end
      ST_DATA1: begin
        state_nxt = ST_CTRL;
      end
    endcase
  end

  // bit counter, shifter and sequencer
  always_ff @(posedge i_spi_sclk) begin
    if (lrst_s2_r | ~lmode_s2_r) begin
      state_r <= ST_CTRL;
      bit_cnt_r <= `BIT_CNT_RST;
      shift_r <= '0;
    end else if (i_spi_cs_n) begin
      if (bit_cnt_r != `BIT_CNT_RST) begin
        state_r <= ST_CTRL;
        bit_cnt_r <= `BIT_CNT_RST;
      end
    end else begin
      shift_r <= rx_byte[`BYTE_W-2:0];
      bit_cnt_r <= bit_cnt_r + `BIT_CNT_W'(1);
      if (byte_done) begin
        state_r <= state_nxt;
      end
    end
  end

  // fields of the operation, latched per byte
  always_ff @(posedge i_spi_sclk) begin
    if (lrst_s2_r) begin
      bcast_r <= 1'b0;
      read_r <= 1'b0;
      sel_r <= 1'b0;
      addr_r <= '0;
      data0_r <= '0;
      tx_r <= '0;
    end else if (byte_done) begin
      unique case (state_r)
        ST_CTRL: begin
          bcast_r <= rx_byte[`CTL_BCAST_BIT];
          read_r <= rx_byte[`CTL_READ_BIT];
          sel_r <= rx_sel;
        end
        // read word fetched at address end
        ST_ADDR: begin
          addr_r <= rx_addr;
          tx_r <= {regs_r[rx_addr], regs_r[rx_addr_p1]};
        end
        ST_DATA0: begin
          data0_r <= rx_byte;
        end
        ST_DATA1: begin
          data0_r <= data0_r;
        end
      endcase
    end
  end

  // register writes
  // a 16-bit controller writes the address and the one after it
  always_ff @(posedge i_spi_sclk) begin
    if (lrst_s2_r) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs_r[i] <= `REG_RST_VAL;
      end
    end else if (byte_done & do_write) begin
      if (state_r == ST_DATA0) begin
        regs_r[addr_r] <= rx_byte;
      end else if (state_r == ST_DATA1) begin
        regs_r[addr_p1] <= rx_byte;
      end
    end
  end

  // write report toward the core, word held until the next write
  always_ff @(posedge i_spi_sclk) begin
    if (lrst_s2_r) begin
      wtog_r <= 1'b0;
      wr_hold_r <= '0;
    end else if (byte_done & do_write & last_data) begin
      wtog_r <= ~wtog_r;
      wr_hold_r.addr <= addr_r;
      wr_hold_r.two_bytes <= (state_r == ST_DATA1);
      wr_hold_r.data <= (state_r == ST_DATA1) ? {data0_r, rx_byte} : {rx_byte, `BYTE_W'(0)};
    end
  end

  // serial id decrement state
  // lsb arrives first, so a running borrow decrements on the fly
  always_ff @(posedge i_spi_sclk) begin
    if (lrst_s2_r | i_spi_cs_n) begin
      borrow_r <= 1'b1;
      bcast_first_r <= 1'b0;
    end else if (state_r == ST_CTRL) begin
      if (bit_cnt_r == `BIT_CNT_RST) begin
        bcast_first_r <= i_spi_sdi;
        borrow_r <= 1'b1;
      end else if (in_id) begin
        borrow_r <= borrow_r & ~i_spi_sdi;
      end
    end
  end

  // pass-through to next device
  // combinational so the chain adds no clock of delay per device
  assign o_chain_pass_out = (in_id & ~bcast_first_r) ? (i_spi_sdi ^ borrow_r) : i_spi_sdi;

  // read bits launched on falling edges
  // the first bit appears on the falling edge after the address byte
  always_ff @(negedge i_spi_sclk) begin
    if (lrst_s2_r) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_r <= tx_r[tx_idx];
      sdo_oe_r <= drive_now & ~i_spi_cs_n;
    end
  end

  // released at once when select drops
  assign o_spi_sdo = sdo_r;
  assign o_spi_sdo_oe = sdo_oe_r & ~i_spi_cs_n;

endmodule

`default_nettype wire

// >>> testbench/spi_chain_port_asserts.sv
// checker for the chained serial control port, core clock domain
// assumes it is bound to spi_chain_port and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module spi_chain_port_asserts (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  input wire logic o_serial_mode,
  input wire logic o_wr_strobe,
  input wire spi_chain_pkg::wr_evt_t o_wr_evt,
  input wire logic o_spi_sdo_oe,
  input wire logic o_chain_pass_out
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // writes are lone pulses, at least sixteen serial clocks apart
  property p_gap; o_wr_strobe |=> !o_wr_strobe [*8]; endproperty
  property p_hold; !$stable(o_wr_evt) |-> o_wr_strobe; endproperty
  property p_pad; o_wr_strobe && !o_wr_evt.two_bytes |-> o_wr_evt.data[7:0] == 8'h00; endproperty
  property p_oe_cs; o_spi_sdo_oe |-> !i_spi_cs_n; endproperty
  property p_oe_mode; o_spi_sdo_oe |-> o_serial_mode; endproperty
  property p_wr_mode; o_wr_strobe |-> o_serial_mode; endproperty
  // outside frames nothing is decremented
  property p_pass; i_spi_cs_n |-> o_chain_pass_out == i_spi_sdi; endproperty
  property p_strap; !$past(i_srst) && !$past(i_srst, 2) |-> $stable(o_serial_mode); endproperty
  property p_rel; $fell(i_srst) |-> !o_wr_strobe && !o_spi_sdo_oe; endproperty
  a_gap: assert property (p_gap) else $error("strobe not lone");
  a_hold: assert property (p_hold) else $error("report moved");
  a_pad: assert property (p_pad) else $error("low byte not zero");
  a_oe_cs: assert property (p_oe_cs) else $error("drives unselected");
  a_oe_mode: assert property (p_oe_mode) else $error("drives in mode 0");
  a_wr_mode: assert property (p_wr_mode) else $error("writes in mode 0");
  a_pass: assert property (p_pass) else $error("pass differs");
  a_strap: assert property (p_strap) else $error("mode moved");
  a_rel: assert property (p_rel) else $error("active at release");
  c_wide: cover property (o_wr_strobe && o_wr_evt.two_bytes);
  c_narrow: cover property (o_wr_strobe && !o_wr_evt.two_bytes);
  c_read: cover property (o_spi_sdo_oe);
endmodule
bind spi_chain_port spi_chain_port_asserts u_spi_chain_port_asserts (.i_core_clk, .i_srst,
  .i_spi_cs_n, .i_spi_sdi, .o_serial_mode, .o_wr_strobe, .o_wr_evt, .o_spi_sdo_oe,
  .o_chain_pass_out);
`default_nettype wire

// >>> testbench/spi_host_model.sv
// serial controller model: 15 ns clock inside and outside frames, idle high
// assumes separate data lines; rx shows x while the device is not driving
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  input wire logic i_pass
);
  logic [15:0] rx_r; // last read bits
  logic [31:0] ps_r; // pass-through log
  initial begin
    o_sclk = 1;
    o_cs_n = 1;
    o_sdi = 0;
  end
  task automatic xb(input int n, input logic [7:0] tx);
    for (int i = 0; i < n; i++) begin
      #7.5 o_sclk = 0;
      o_sdi = tx[7-i];
      #7.5 o_sclk = 1;
      rx_r = {rx_r[14:0], i_sdo_oe ? i_sdo : 1'bx};
      ps_r = {ps_r[30:0], i_pass};
    end
  endtask
  // select changes while the clock is high, except on the first call after park(0)
  task automatic cs(input logic v);
    #7.5 o_cs_n = v;
  endtask
  // clock pin level held as the mode strap across reset
  task automatic park(input logic v);
    o_sclk = v;
  endtask
  // control, address, one or two data bytes
  task automatic op(input logic [7:0] c, a, d0, d1, input logic wide);
    cs(0);
    xb(8, c);
    xb(8, a);
    xb(8, d0);
    if (wide) xb(8, d1);
    cs(1);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the chained serial control port
// assumes the host model drives the serial side and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, srst, wide, sclk, cs_n, sdi, mode, stb, sdo, oe, pass, seen;
  spi_chain_pkg::wr_evt_t evt;
  int fails, samples_checked;
  spi_chain_port u_spi_chain_port (.i_core_clk(clk), .i_srst(srst), .i_wide_data(wide),
    .o_serial_mode(mode), .o_wr_strobe(stb), .o_wr_evt(evt), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe),
    .o_chain_pass_out(pass));
  spi_host_model u_spi_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_sdo(sdo), .i_sdo_oe(oe), .i_pass(pass));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  // bounded watch for a write report
  task automatic wt;
    seen = 0;
    repeat (20) @(negedge clk) if (stb === 1'b1) seen = 1;
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_wr8;
    u_spi_host_model.op(8'h20, 8'hC5, 8'hA5, 8'h00, 0);
    wt;
    chk("seen", 1, seen);
    chk("addr", 16'h0005, evt.addr);
    chk("data", 16'hA500, evt.data);
    chk("two", 0, evt.two_bytes);
    u_spi_host_model.op(8'h60, 8'h05, 8'h00, 8'h00, 0);
    chk("rd", 16'h00A5, u_spi_host_model.rx_r[7:0]);
    $display("done wr8");
  endtask
  task automatic t_chain;
    u_spi_host_model.op(8'h28, 8'h07, 8'h3C, 8'h00, 0);
    wt;
    chk("nosel", 0, seen);
    chk("dec", 16'h0020, u_spi_host_model.ps_r[23:16]);
    u_spi_host_model.op(8'h2F, 8'h07, 8'h3C, 8'h00, 0);
    chk("far", 16'h0027, u_spi_host_model.ps_r[23:16]);
    u_spi_host_model.op(8'h68, 8'h05, 8'h00, 8'h00, 0);
    chk("off", 16'hxxxx, {8'hxx, u_spi_host_model.rx_r[7:0]});
    u_spi_host_model.op(8'hA8, 8'h09, 8'h5A, 8'h00, 0);
    wt;
    chk("bc", 1, seen);
    chk("bcaddr", 16'h0009, evt.addr);
    chk("bcpass", 16'h00A8, u_spi_host_model.ps_r[23:16]);
    u_spi_host_model.op(8'h30, 8'h0A, 8'hFF, 8'h00, 0);
    wt;
    chk("mark", 0, seen);
    $display("done chain");
  endtask
  task automatic t_sync;
    u_spi_host_model.cs(0);
    u_spi_host_model.xb(3, 8'hFF);
    u_spi_host_model.cs(1);
    u_spi_host_model.xb(1, 8'hFF);
    u_spi_host_model.op(8'h20, 8'h0B, 8'h77, 8'h00, 0);
    wt;
    chk("syaddr", 16'h000B, evt.addr);
    chk("sydata", 16'h7700, evt.data);
    $display("done sync");
  endtask
  task automatic t_wide;
    @(negedge clk) wide = 1;
    repeat (4) @(negedge clk);
    u_spi_host_model.op(8'h20, 8'h3F, 8'h12, 8'h34, 1);
    wt;
    chk("waddr", 16'h003F, evt.addr);
    chk("wdata", 16'h1234, evt.data);
    chk("wtwo", 1, evt.two_bytes);
    u_spi_host_model.op(8'h60, 8'h3F, 8'h00, 8'h00, 1);
    chk("wrd", 16'h1234, u_spi_host_model.rx_r);
    $display("done wide");
  endtask
  // low serial clock at reset release parks the port in highway mode
  task automatic t_mode;
    @(negedge clk) srst = 1;
    u_spi_host_model.xb(3, 8'h00);
    @(negedge clk) u_spi_host_model.park(0);
    repeat (5) @(negedge clk);
    srst = 0;
    repeat (4) @(negedge clk);
    chk("mode0", 0, mode);
    u_spi_host_model.op(8'h20, 8'h0C, 8'h5A, 8'h00, 0);
    wt;
    chk("m0wr", 0, seen);
    u_spi_host_model.op(8'h60, 8'h0C, 8'h00, 8'h00, 0);
    chk("m0rd", 16'hxxxx, {8'hxx, u_spi_host_model.rx_r[7:0]});
    $display("done mode");
  endtask
  initial begin
    #400000;
    fails++;
    stop_test;
  end
  initial begin
    srst = 1;
    wide = 0;
    fails = 0;
    samples_checked = 0;
    u_spi_host_model.xb(3, 8'h00);
    repeat (5) @(negedge clk);
    srst = 0;
    repeat (4) @(negedge clk);
    u_spi_host_model.xb(4, 8'h00);
    chk("mode", 1, mode);
    t_wr8;
    t_chain;
    t_sync;
    t_wide;
    t_mode;
    stop_test;
  end
endmodule
`default_nettype wire
